// *** ida_pkg.sv ***
// package for the internal device address map
package ida_pkg;
   localparam int IDA_AW = 4;
   localparam int IDA_DW = 16;
   localparam logic [3:0] IDA_OFF_CTRL = 4'h0;
   localparam logic [3:0] IDA_OFF_STAT = 4'h1;
   localparam logic [3:0] IDA_OFF_RESULT = 4'h2;
   localparam logic [3:0] IDA_OFF_LATCH0 = 4'h3;
   localparam logic [3:0] IDA_OFF_LATCH1 = 4'h4;
   localparam logic [3:0] IDA_OFF_DMA = 4'h5;
   localparam logic [3:0] IDA_OFF_SENS0 = 4'h6;
   localparam logic [3:0] IDA_OFF_SENS1 = 4'h7;
   localparam logic [3:0] IDA_OFF_SENS2 = 4'h8;
   localparam logic [3:0] IDA_OFF_TUNE = 4'h9;
   localparam logic [15:0] IDA_RST_CTRL = 16'h0000;
   localparam logic [15:0] IDA_RST_LATCH0 = 16'h0000;
   localparam logic [15:0] IDA_RST_LATCH1 = 16'h0003;
   localparam logic [15:0] IDA_RST_TUNE = 16'h0000;
   localparam logic [15:0] IDA_TUNE_MASK = 16'h001F;
   localparam logic [15:0] IDA_LATCH1_MASK = 16'hFF0F;
   localparam logic [15:0] IDA_RFID_LOCK_MASK = 16'hFF00;
   // status word bit positions
   localparam int IDA_ST_READY = 0;
   localparam int IDA_ST_BUSY = 1;
   localparam int IDA_ST_OTHER = 2;
   localparam int IDA_ST_LOADING = 3;
   // eeprom layout
   localparam int IDA_EE_WORDS = 256;
   localparam int IDA_EE_CFG_WORDS = 39;
   localparam int IDA_EE_BACKUP_WORDS = 2;
   localparam int IDA_EE_APP_WORDS = 215;
   localparam int IDA_CLK_HZ = 5000000;
   // memory domains
   typedef enum logic [1:0] {IDA_DOM_EEPROM, IDA_DOM_REGFILE, IDA_DOM_DEVICE, IDA_DOM_EXTMEM} ida_dom_e;
   typedef struct packed {
      logic valid;
      logic write;
      ida_dom_e dom;
      logic [7:0] addr;
      logic [15:0] wdata;
   } ida_req_s;
   typedef struct packed {
      logic done;
      logic [15:0] rdata;
   } ida_rsp_s;
endpackage : ida_pkg

// *** ida_sync.sv ***
// two flop synchroniser for pin inputs
`timescale 1ns/10ps
module ida_sync #(parameter int W = 1) (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta;
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         meta <= '0;
         q_o <= '0;
      end else begin
         meta <= d_i;
         q_o <= meta;
      end
   end
endmodule : ida_sync

// *** ida_arbiter.sv ***
// two host arbiter granting one access at a time
`timescale 1ns/10ps
module ida_arbiter (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic req_spi_i,
   input wire logic req_rfid_i,
   input wire logic done_i,
   output logic gnt_spi_o,
   output logic gnt_rfid_o
);
   logic owner;
   logic busy;
   logic last;
   logic next_owner;
   logic next_busy;
   logic next_last;
   always_comb begin
      next_owner = owner;
      next_busy = busy;
      next_last = last;
      if (busy) begin
         if (done_i) begin
            next_busy = 1'b0;
            next_last = owner;
         end
      end else if (req_spi_i && req_rfid_i) begin
         next_busy = 1'b1;
         next_owner = ~last;
      end else if (req_spi_i || req_rfid_i) begin
         next_busy = 1'b1;
         next_owner = req_rfid_i;
      end
   end
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         owner <= 1'b0;
         busy <= 1'b0;
         last <= 1'b1;
      end else begin
         owner <= next_owner;
         busy <= next_busy;
         last <= next_last;
      end
   end
   assign gnt_spi_o = busy && !owner;
   assign gnt_rfid_o = busy && owner;
endmodule : ida_arbiter

// *** ida_core.sv ***
// internal device register space and memory domain decoder
// Operation
// RULE1 - four domains: eeprom, regfile, devices, external
// RULE2 - external domain reached as spi master
// RULE3 - regfile loaded from eeprom on start or reload
// RULE4 - regfile volatile, rewritten each power up
// RULE5 - device registers not loaded from eeprom
// RULE6 - eeprom 256 words: 39 config, 2 backup, 215 app
// RULE7 - spi and rfid concurrent, core arbitrates
// RULE8 - separate control/status words per host
// RULE9 - 0x00 control, 0x01 status, 0x02 buffer
// RULE10 - local buffer keeps last transaction result; device domain accesses other than sensor reads leave it unchanged
// RULE11 - 0x03 0x04 0x09 latch words, both hosts; rfid writes to 0x04 change only bits 3:0
// RULE12 - 0x09 drives antenna tuning capacitance code
// RULE13 - 0x05 reports dma destination address
// RULE14 - 0x06..0x08 select sensor result buffers
// RULE15 - reading sensor buffer powers sensor, converts
// RULE16 - conversion result copied to requester buffer
// RULE17 - sample is a 16 bit code
// RULE18 - controller clocked by 5 MHz oscillator
// RULE19 - host waits or polls ready before reading
// RULE20 - simultaneous requests granted one at a time
`timescale 1ns/10ps
module ida_core
   import ida_pkg::*;
#(
   parameter int RELOAD_WORDS = IDA_EE_CFG_WORDS
) (
   input wire logic sys_clk_i, // RULE18
   input wire logic reset_i,
   input wire ida_req_s spi_req_i,
   output ida_rsp_s spi_rsp_o,
   input wire ida_req_s rfid_req_i,
   output ida_rsp_s rfid_rsp_o,
   input wire logic reload_pin_i,
   input wire logic [15:0] dma_addr_i,
   input wire logic adc_done_i,
   input wire logic [15:0] adc_code_i,
   output logic [1:0] sensor_sel_o,
   output logic sensor_power_o,
   output logic adc_start_o,
   output logic ee_req_o,
   output logic ee_write_o,
   output logic [7:0] ee_addr_o,
   output logic [15:0] ee_wdata_o,
   input wire logic ee_ack_i,
   input wire logic [15:0] ee_rdata_i,
   output logic ext_req_o,
   output logic ext_write_o,
   output logic [7:0] ext_addr_o,
   output logic [15:0] ext_wdata_o,
   input wire logic ext_ack_i,
   input wire logic [15:0] ext_rdata_i,
   output logic [15:0] latch0_o,
   output logic [15:0] latch1_o,
   output logic [4:0] antenna_tuning_code_o
);
   typedef enum {ST_LOAD, ST_IDLE, ST_EE, ST_EXT, ST_CONV, ST_DONE} ida_state_e;
   ida_state_e state, next_state;
   logic [7:0] load_idx, next_load_idx;
   logic [15:0] regfile [0:255];
   logic [15:0] ctrl [0:1];
   logic [15:0] stat [0:1];
   logic [15:0] result [0:1];
   logic [15:0] sens [0:2];
   logic [15:0] latch0, latch1, tune;
   logic [15:0] next_ctrl [0:1];
   logic [15:0] next_stat [0:1];
   logic [15:0] next_result [0:1];
   logic [15:0] next_sens [0:2];
   logic [15:0] next_latch0, next_latch1, next_tune;
   logic [15:0] rdata, next_rdata;
   logic [1:0] sel, next_sel;
   logic done, next_done;
   logic gnt_spi, gnt_rfid, owner, reload_s, reload_d;
   logic rf_we;
   logic [15:0] dma_s, adc_s;
   logic adc_done_s;
   ida_req_s req;

   function automatic logic [15:0] latch_wr(input logic [15:0] old, input logic [15:0] wd,
                                             input logic [15:0] mask);
      latch_wr = (old & ~mask) | (wd & mask);
   endfunction : latch_wr

   ida_sync #(.W(34)) u_sync (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .d_i({reload_pin_i, adc_done_i, dma_addr_i, adc_code_i}),
      .q_o({reload_s, adc_done_s, dma_s, adc_s})
   );

   ida_arbiter u_arb ( // RULE7 RULE20
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .req_spi_i(spi_req_i.valid && state == ST_IDLE && !spi_rsp_o.done),
      .req_rfid_i(rfid_req_i.valid && state == ST_IDLE && !rfid_rsp_o.done),
      .done_i(done),
      .gnt_spi_o(gnt_spi),
      .gnt_rfid_o(gnt_rfid)
   );

   assign owner = gnt_rfid;
   assign req = owner ? rfid_req_i : spi_req_i;

   always_comb begin
      next_state = state;
      next_load_idx = load_idx;
      next_ctrl = ctrl;
      next_stat = stat;
      next_result = result;
      next_sens = sens;
      next_latch0 = latch0;
      next_latch1 = latch1;
      next_tune = tune;
      next_rdata = rdata;
      next_sel = sel;
      next_done = 1'b0;
      rf_we = 1'b0;
      for (int h = 0; h < 2; h++) begin
         next_stat[h][IDA_ST_BUSY] = (state != ST_IDLE); // RULE7
         next_stat[h][IDA_ST_LOADING] = (state == ST_LOAD);
      end
      next_stat[0][IDA_ST_OTHER] = gnt_rfid; // RULE8
      next_stat[1][IDA_ST_OTHER] = gnt_spi;
      case (state)
         ST_LOAD: begin
            if (ee_ack_i) begin
               rf_we = 1'b1; // RULE3 RULE4
               if (load_idx == 8'(RELOAD_WORDS - 1)) begin
                  next_state = ST_IDLE;
                  next_load_idx = 8'h00;
               end else begin
                  next_load_idx = load_idx + 8'h01;
               end
            end
         end
         ST_IDLE: begin
            if (reload_s && !reload_d) begin
               next_state = ST_LOAD; // RULE3
            end else if ((gnt_spi || gnt_rfid) && !done) begin
               case (req.dom) // RULE1
                  IDA_DOM_EEPROM: next_state = ST_EE;
                  IDA_DOM_EXTMEM: next_state = ST_EXT; // RULE2
                  IDA_DOM_REGFILE: begin
                     if (req.write) rf_we = 1'b1;
                     next_rdata = regfile[req.addr];
                     next_state = ST_DONE;
                  end
                  default: begin // RULE5
                     next_state = ST_DONE;
                     if (req.addr == 8'(IDA_OFF_CTRL)) begin // RULE9
                        if (req.write) next_ctrl[owner] = req.wdata;
                        next_rdata = ctrl[owner];
                     end else if (req.addr == 8'(IDA_OFF_STAT)) begin
                        next_rdata = stat[owner];
                     end else if (req.addr == 8'(IDA_OFF_RESULT)) begin
                        next_rdata = result[owner]; // RULE10
                     end else if (req.addr == 8'(IDA_OFF_LATCH0)) begin // RULE11
                        if (req.write) next_latch0 = req.wdata;
                        next_rdata = latch0;
                     end else if (req.addr == 8'(IDA_OFF_LATCH1)) begin
                        if (req.write) begin
                           next_latch1 = latch_wr(latch1, req.wdata,
                              owner ? (IDA_LATCH1_MASK & ~IDA_RFID_LOCK_MASK) : IDA_LATCH1_MASK);
                        end
                        next_rdata = latch1;
                     end else if (req.addr == 8'(IDA_OFF_DMA)) begin
                        next_rdata = dma_s; // RULE13
                     end else if (req.addr >= 8'(IDA_OFF_SENS0) && req.addr <= 8'(IDA_OFF_SENS2)) begin
                        if (!req.write) begin // RULE14 RULE15
                           next_sel = 2'(req.addr - 8'(IDA_OFF_SENS0));
                           next_stat[owner][IDA_ST_READY] = 1'b0;
                           next_state = ST_CONV;
                        end else begin
                           next_rdata = 16'h0000;
                        end
                     end else if (req.addr == 8'(IDA_OFF_TUNE)) begin // RULE12
                        if (req.write) next_tune = req.wdata & IDA_TUNE_MASK;
                        next_rdata = tune;
                     end else begin
                        next_rdata = 16'h0000;
                     end
                  end
               endcase
            end
         end
         ST_EE: begin
            if (ee_ack_i) begin
               next_rdata = ee_rdata_i;
               next_state = ST_DONE;
            end
         end
         ST_EXT: begin
            if (ext_ack_i) begin
               next_rdata = ext_rdata_i;
               next_state = ST_DONE;
            end
         end
         ST_CONV: begin
            if (adc_done_s) begin
               next_sens[sel] = adc_s; // RULE15 RULE17
               next_result[owner] = adc_s; // RULE16
               next_stat[owner][IDA_ST_READY] = 1'b1; // RULE19
               next_rdata = adc_s;
               next_state = ST_DONE;
            end
         end
         ST_DONE: begin
            next_done = 1'b1;
            if (next_rdata == rdata && req.dom != IDA_DOM_DEVICE) next_result[owner] = rdata; // RULE10
            next_state = ST_IDLE;
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         state <= ST_LOAD; // RULE3
         load_idx <= 8'h00;
         ctrl <= '{default: IDA_RST_CTRL};
         stat <= '{default: 16'h0000};
         result <= '{default: 16'h0000};
         sens <= '{default: 16'h0000};
         latch0 <= IDA_RST_LATCH0;
         latch1 <= IDA_RST_LATCH1;
         tune <= IDA_RST_TUNE;
         rdata <= 16'h0000;
         sel <= 2'b00;
         done <= 1'b0;
         reload_d <= 1'b0;
      end else begin
         state <= next_state;
         load_idx <= next_load_idx;
         ctrl <= next_ctrl;
         stat <= next_stat;
         result <= next_result;
         sens <= next_sens;
         latch0 <= next_latch0;
         latch1 <= next_latch1;
         tune <= next_tune;
         rdata <= next_rdata;
         sel <= next_sel;
         done <= next_done;
         reload_d <= reload_s;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rf_we) begin
         if (state == ST_LOAD) regfile[load_idx] <= ee_rdata_i;
         else regfile[req.addr] <= req.wdata;
      end
   end

   // no eeprom traffic while reset holds the load state
   assign ee_req_o = (state == ST_LOAD && !reset_i) || (state == ST_EE);
   assign ee_write_o = (state == ST_EE) && req.write;
   assign ee_addr_o = (state == ST_LOAD) ? load_idx : req.addr; // RULE6
   assign ee_wdata_o = req.wdata;
   assign ext_req_o = (state == ST_EXT); // RULE2
   assign ext_write_o = (state == ST_EXT) && req.write;
   assign ext_addr_o = req.addr;
   assign ext_wdata_o = req.wdata;
   assign sensor_power_o = (state == ST_CONV); // RULE15
   assign sensor_sel_o = sel;
   assign adc_start_o = (state == ST_CONV);
   assign spi_rsp_o = '{done: done && !owner, rdata: rdata};
   assign rfid_rsp_o = '{done: done && owner, rdata: rdata};
   assign latch0_o = latch0;
   assign latch1_o = latch1;
   assign antenna_tuning_code_o = tune[4:0]; // RULE12

   a_conv_done: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RULE16
      (state == ST_CONV && adc_done_s) |=> (result[owner] == $past(adc_s))) else $error("result not copied");
   a_tune_mask: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RULE12
      tune[15:5] == 11'h000) else $error("tune upper bits set");
   a_one_grant: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RULE20
      !(gnt_spi && gnt_rfid)) else $error("two grants");
   a_power_conv: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RULE15
      sensor_power_o == (state == ST_CONV)) else $error("sensor power wrong");
   a_load_start: assert property (@(posedge sys_clk_i) // RULE3
      reset_i |=> state == ST_LOAD) else $error("no load after reset");
   a_ext_master: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RULE2
      (state == ST_IDLE && gnt_spi && !done && req.dom == IDA_DOM_EXTMEM) |=> ext_req_o) else $error("ext miss");
   a_dma_read: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RULE13
      (state == ST_IDLE && (gnt_spi || gnt_rfid) && !done && req.dom == IDA_DOM_DEVICE
       && req.addr == 8'(IDA_OFF_DMA)) |=> rdata == $past(dma_s)) else $error("dma read wrong");
   a_ready_bit: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RULE19
      (state == ST_CONV) |-> !stat[owner][IDA_ST_READY]) else $error("ready early");
endmodule : ida_core

// *** ida_far_model.sv ***
// far side model: eeprom, external memory and sensor converter
`timescale 1ns/10ps
module ida_far_model (
   input wire logic sys_clk_i,
   input wire logic [1:0] stall_i,
   input wire logic [15:0] code_base_i,
   input wire logic ee_req_i,
   input wire logic ee_write_i,
   input wire logic [7:0] ee_addr_i,
   input wire logic [15:0] ee_wdata_i,
   output logic ee_ack_o,
   output logic [15:0] ee_rdata_o,
   input wire logic ext_req_i,
   input wire logic ext_write_i,
   input wire logic [7:0] ext_addr_i,
   input wire logic [15:0] ext_wdata_i,
   output logic ext_ack_o,
   output logic [15:0] ext_rdata_o,
   input wire logic adc_start_i,
   input wire logic [1:0] sensor_sel_i,
   input wire logic sensor_power_i,
   output logic adc_done_o,
   output logic [15:0] adc_code_o,
   output logic [15:0] ee_reads_o,
   output logic [1:0] sel_seen_o,
   output logic power_seen_o
);
   logic [15:0] ee_mem [256];
   logic [15:0] ext_mem [256];
   logic [1:0] ee_wait, ext_wait;
   logic adc_q;
   int adc_cnt;
   initial begin
      for (int i = 0; i < 256; i++) begin
         ee_mem[i] = 16'hC300 ^ 16'(i);
         ext_mem[i] = 16'h3C00 ^ 16'(i);
      end
      {ee_ack_o, ext_ack_o, adc_done_o, adc_q, power_seen_o} = '0;
      {ee_rdata_o, ext_rdata_o, adc_code_o, ee_reads_o, ee_wait, ext_wait, sel_seen_o} = '0;
      adc_cnt = 0;
   end
   // eeprom side: ack after a stall, released data lines toggle
   always @(posedge sys_clk_i) begin
      ee_ack_o <= 1'b0;
      ee_rdata_o <= ~ee_rdata_o;
      if (ee_req_i && !ee_ack_o) begin
         if (ee_wait < stall_i) ee_wait <= ee_wait + 2'h1;
         else begin
            ee_wait <= 2'h0;
            ee_ack_o <= 1'b1;
            ee_rdata_o <= ee_mem[ee_addr_i];
            if (ee_write_i) ee_mem[ee_addr_i] <= ee_wdata_i;
            else ee_reads_o <= ee_reads_o + 16'h1;
         end
      end
   end
   // external memory reached over the spi master port
   always @(posedge sys_clk_i) begin
      ext_ack_o <= 1'b0;
      ext_rdata_o <= ~ext_rdata_o;
      if (ext_req_i && !ext_ack_o) begin
         if (ext_wait < stall_i) ext_wait <= ext_wait + 2'h1;
         else begin
            ext_wait <= 2'h0;
            ext_ack_o <= 1'b1;
            ext_rdata_o <= ext_mem[ext_addr_i];
            if (ext_write_i) ext_mem[ext_addr_i] <= ext_wdata_i;
         end
      end
   end
   // converter: slow result, 16 bit code held until start drops
   always @(posedge sys_clk_i) begin
      adc_q <= adc_start_i;
      if (adc_start_i && !adc_q) begin
         sel_seen_o <= sensor_sel_i;
         adc_cnt <= 20;
      end else if (adc_cnt > 1) adc_cnt <= adc_cnt - 1;
      else if (adc_cnt == 1) begin
         adc_cnt <= 0;
         power_seen_o <= sensor_power_i;
         adc_done_o <= 1'b1;
         adc_code_o <= code_base_i ^ {14'h0000, sel_seen_o};
      end
      if (!adc_start_i && adc_done_o) begin
         adc_done_o <= 1'b0;
         adc_code_o <= ~adc_code_o;
      end
   end
endmodule : ida_far_model

// *** tb_internal_device_address_map.sv ***
// testbench for the internal device address map
`timescale 1ns/10ps
module tb_internal_device_address_map;
   import ida_pkg::*;
   logic sys_clk_i = 1'b0, reset_i = 1'b1, reload_pin_i = 1'b0;
   logic [15:0] dma_addr_i = 16'h0000, code_base = 16'h0000, rd, v, e1, ee_reads;
   logic [1:0] stall = 2'h0, sel_seen;
   logic power_seen;
   ida_req_s req [2];
   ida_rsp_s rsp [2];
   logic adc_done_i, ee_ack_i, ext_ack_i, sensor_power_o, adc_start_o, ee_req_o, ee_write_o, ext_req_o, ext_write_o;
   logic [15:0] adc_code_i, ee_rdata_i, ext_rdata_i, ee_wdata_o, ext_wdata_o, latch0_o, latch1_o;
   logic [7:0] ee_addr_o, ext_addr_o;
   logic [1:0] sensor_sel_o;
   logic [4:0] antenna_tuning_code_o;
   int err_count = 0, checked = 0, cycles = 0;
   logic [31:0] rng = 32'd64334;
   always #5 sys_clk_i = ~sys_clk_i;
   ida_core #(.RELOAD_WORDS(4)) DUT (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .spi_req_i(req[0]),
      .spi_rsp_o(rsp[0]), .rfid_req_i(req[1]), .rfid_rsp_o(rsp[1]), .reload_pin_i(reload_pin_i),
      .dma_addr_i(dma_addr_i), .adc_done_i(adc_done_i), .adc_code_i(adc_code_i), .sensor_sel_o(sensor_sel_o),
      .sensor_power_o(sensor_power_o), .adc_start_o(adc_start_o), .ee_req_o(ee_req_o), .ee_write_o(ee_write_o),
      .ee_addr_o(ee_addr_o), .ee_wdata_o(ee_wdata_o), .ee_ack_i(ee_ack_i), .ee_rdata_i(ee_rdata_i),
      .ext_req_o(ext_req_o), .ext_write_o(ext_write_o), .ext_addr_o(ext_addr_o), .ext_wdata_o(ext_wdata_o),
      .ext_ack_i(ext_ack_i), .ext_rdata_i(ext_rdata_i), .latch0_o(latch0_o), .latch1_o(latch1_o),
      .antenna_tuning_code_o(antenna_tuning_code_o));
   ida_far_model far (.sys_clk_i(sys_clk_i), .stall_i(stall), .code_base_i(code_base), .ee_req_i(ee_req_o),
      .ee_write_i(ee_write_o), .ee_addr_i(ee_addr_o), .ee_wdata_i(ee_wdata_o), .ee_ack_o(ee_ack_i),
      .ee_rdata_o(ee_rdata_i), .ext_req_i(ext_req_o), .ext_write_i(ext_write_o), .ext_addr_i(ext_addr_o),
      .ext_wdata_i(ext_wdata_o), .ext_ack_o(ext_ack_i), .ext_rdata_o(ext_rdata_i), .adc_start_i(adc_start_o),
      .sensor_sel_i(sensor_sel_o), .sensor_power_i(sensor_power_o), .adc_done_o(adc_done_i),
      .adc_code_o(adc_code_i), .ee_reads_o(ee_reads), .sel_seen_o(sel_seen), .power_seen_o(power_seen));
   function automatic logic [15:0] rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng[15:0];
   endfunction : rnd
   function automatic logic [15:0] exp_latch1(input int h, input logic [15:0] old, input logic [15:0] wd);
      if (h == 1) return (old & IDA_RFID_LOCK_MASK) | (wd & IDA_LATCH1_MASK & ~IDA_RFID_LOCK_MASK);
      return wd & IDA_LATCH1_MASK;
   endfunction : exp_latch1
   task automatic final_report();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : final_report
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   // host request held until done, dropped in the done cycle
   task automatic xfer(input int h, input logic wr, input ida_dom_e dom, input logic [7:0] a,
                       input logic [15:0] wd, output logic [15:0] r);
      int n;
      @(negedge sys_clk_i);
      req[h] = '{1'b1, wr, dom, a, wd};
      n = 0;
      do begin
         @(negedge sys_clk_i);
         n++;
      end while (rsp[h].done !== 1'b1 && n < 2000);
      check("done", 16'(n < 2000), 16'h0001);
      r = rsp[h].rdata;
      req[h].valid = 1'b0;
   endtask : xfer
   task automatic wait_ee_idle();
      int idle;
      idle = 0;
      for (int n = 0; n < 3000 && idle < 30; n++) begin
         @(negedge sys_clk_i);
         idle = ee_req_o ? 0 : idle + 1;
      end
   endtask : wait_ee_idle
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 60000) begin
         err_count++;
         final_report();
      end
   end
   initial begin
      req[0] = '0;
      req[1] = '0;
      dma_addr_i = rnd();
      stall = 2'(rnd());
      repeat (16) @(negedge sys_clk_i);
      reset_i = 1'b0;
      wait_ee_idle();
      check("load reads", ee_reads, 16'h0004);
      xfer(0, 0, IDA_DOM_REGFILE, 8'h02, 16'h0000, rd); check("regfile load", rd, 16'hC302);
      xfer(0, 0, IDA_DOM_DEVICE, 8'h00, 16'h0000, rd); check("ctrl rst", rd, IDA_RST_CTRL);
      xfer(1, 0, IDA_DOM_DEVICE, 8'h03, 16'h0000, rd); check("latch0 rst", rd, IDA_RST_LATCH0);
      xfer(0, 0, IDA_DOM_DEVICE, 8'h04, 16'h0000, rd); check("latch1 rst", rd, IDA_RST_LATCH1);
      xfer(1, 0, IDA_DOM_DEVICE, 8'h09, 16'h0000, rd); check("tune rst", rd, IDA_RST_TUNE);
      e1 = IDA_RST_LATCH1;
      for (int i = 0; i < 6; i++) begin
         int h;
         h = i % 2;
         v = rnd();
         xfer(h, 1, IDA_DOM_DEVICE, 8'h03, v, rd);
         xfer(h, 1, IDA_DOM_DEVICE, 8'h04, v, rd);
         xfer(h, 1, IDA_DOM_DEVICE, 8'h09, v, rd);
         e1 = exp_latch1(h, e1, v);
         xfer(1 - h, 0, IDA_DOM_DEVICE, 8'h03, 16'h0000, rd); check("latch0", rd, v);
         xfer(1 - h, 0, IDA_DOM_DEVICE, 8'h04, 16'h0000, rd); check("latch1", rd, e1);
         xfer(1 - h, 0, IDA_DOM_DEVICE, 8'h09, 16'h0000, rd); check("tune", rd, v & IDA_TUNE_MASK);
         check("latch0 pin", latch0_o, v);
         check("latch1 pin", latch1_o, e1);
         check("tune pin", 16'(antenna_tuning_code_o), v & IDA_TUNE_MASK);
      end
      v = rnd();
      xfer(0, 1, IDA_DOM_DEVICE, 8'h00, v, rd);
      xfer(1, 1, IDA_DOM_DEVICE, 8'h00, ~v, rd);
      xfer(0, 0, IDA_DOM_DEVICE, 8'h00, 16'h0000, rd); check("spi ctrl", rd, v);
      xfer(1, 0, IDA_DOM_DEVICE, 8'h00, 16'h0000, rd); check("rfid ctrl", rd, ~v);
      for (int a = 10; a < 16; a++) begin
         xfer(a % 2, 1, IDA_DOM_DEVICE, 8'(a), rnd(), rd);
         xfer(a % 2, 0, IDA_DOM_DEVICE, 8'(a), 16'h0000, rd); check("unmapped", rd, 16'h0000);
      end
      xfer(1, 1, IDA_DOM_DEVICE, 8'h05, ~dma_addr_i, rd);
      xfer(1, 0, IDA_DOM_DEVICE, 8'h05, 16'h0000, rd); check("dma", rd, dma_addr_i);
      for (int s = 0; s < 3; s++) begin
         int h;
         logic [15:0] other;
         h = s % 2;
         code_base = rnd();
         xfer(1 - h, 0, IDA_DOM_DEVICE, 8'h02, 16'h0000, other);
         xfer(h, 0, IDA_DOM_DEVICE, 8'(6 + s), 16'h0000, rd); check("sensor", rd, code_base ^ 16'(s));
         check("sel", 16'(sel_seen), 16'(s));
         check("power", 16'(power_seen), 16'h0001);
         xfer(h, 0, IDA_DOM_DEVICE, 8'h01, 16'h0000, rd); check("ready", 16'(rd[IDA_ST_READY]), 16'h0001);
         xfer(h, 0, IDA_DOM_DEVICE, 8'h02, 16'h0000, rd); check("buffer", rd, code_base ^ 16'(s));
         xfer(1 - h, 0, IDA_DOM_DEVICE, 8'h02, 16'h0000, rd); check("other buf", rd, other);
      end
      v = rnd();
      e1 = rnd();
      stall = 2'h3;
      xfer(0, 1, IDA_DOM_EEPROM, 8'h40, v, rd);
      xfer(1, 1, IDA_DOM_EXTMEM, 8'h12, e1, rd);
      fork
         begin xfer(0, 0, IDA_DOM_EXTMEM, 8'h12, 16'h0000, rd); check("ext", rd, e1); end
         begin logic [15:0] r2; xfer(1, 0, IDA_DOM_EEPROM, 8'h40, 16'h0000, r2); check("ee", r2, v); end
      join
      fork
         xfer(0, 1, IDA_DOM_DEVICE, 8'h03, v, rd);
         begin logic [15:0] r3; xfer(1, 1, IDA_DOM_DEVICE, 8'h03, e1, r3); end
      join
      xfer(0, 0, IDA_DOM_DEVICE, 8'h03, 16'h0000, rd); check("arb order", rd, e1);
      xfer(1, 1, IDA_DOM_REGFILE, 8'h02, ~e1, rd);
      xfer(0, 0, IDA_DOM_REGFILE, 8'h02, 16'h0000, rd); check("regfile wr", rd, ~e1);
      v = ee_reads;
      @(negedge sys_clk_i);
      reload_pin_i = 1'b1;
      repeat (4) @(negedge sys_clk_i);
      reload_pin_i = 1'b0;
      wait_ee_idle();
      check("reload reads", ee_reads - v, 16'h0004);
      xfer(0, 0, IDA_DOM_REGFILE, 8'h02, 16'h0000, rd); check("regfile reload", rd, 16'hC302);
      xfer(1, 0, IDA_DOM_DEVICE, 8'h03, 16'h0000, rd); check("latch kept", rd, e1);
      final_report();
   end
endmodule : tb_internal_device_address_map
